// *** src/pmx_exchange.v ***
`timescale 1ns/1ps
`include "pmx_defs.vh"
module pmx_exchange #(
  parameter DEPTH = `PMX_FIFO_DEPTH
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Program memory data bus, three signals
  input wire [23:0] program_memory_data_bus_in,
  output reg [23:0] program_memory_data_bus_out,
  output reg program_memory_data_bus_oe,
  // Data memory data bus, three signals
  input wire [15:0] data_memory_data_bus_in,
  output reg [15:0] data_memory_data_bus_out,
  output reg data_memory_data_bus_oe,
  // Transfer controls from sequencer
  input wire pm_data_read,
  input wire pm_data_write,
  input wire pm_dual_read,
  input wire ext_load_dmd,
  input wire ext_read_dmd,
  // Write source register stream into the exchange
  input wire wr_valid,
  output reg wr_ready,
  // Read results toward destination registers
  output reg rd_valid,
  input wire rd_ready,
  output reg [15:0] rd_data,
  // Dedicated Y operand path and extension view
  output reg [15:0] y_operand_data,
  output reg y_operand_valid,
  output reg [7:0] pm_low_byte_extension
);
  // ==========================================
  // Decode helpers
  // ==========================================
  // Data word read from program memory
  function pm_word_read;
    input rd;
    input dual;
    begin
      pm_word_read = rd && !dual;
    end
  endfunction

  // Result pushed into the read FIFO
  function rd_push_dec;
    input rd;
    input dual;
    input ext_rd;
    begin
      rd_push_dec = pm_word_read(rd, dual) || ext_rd;
    end
  endfunction

  // Pointer width for a FIFO depth
  function integer addr_bits;
    input integer depth;
    integer span;
    begin
      addr_bits = 1;
      for (span = 2; span < depth; span = span * 2) begin
        addr_bits = addr_bits + 1;
      end
    end
  endfunction

  // ==========================================
  // Widths and depths
  // ==========================================
  localparam PMD_W = `PMX_PMD_W;
  localparam DMD_W = `PMX_DMD_W;
  localparam EXT_W = `PMX_EXT_W;
  localparam LANES = PMD_W / EXT_W;
  localparam FIFO_AW = addr_bits(DEPTH);

  // ==========================================
  // Decoded transfer kinds
  // ==========================================
  wire word_read;
  wire read_push;
  wire write_drive;
  assign word_read = pm_word_read(pm_data_read, pm_dual_read);
  assign read_push = rd_push_dec(pm_data_read, pm_dual_read, ext_read_dmd);
  assign write_drive = pm_data_write && wr_valid;

  // ==========================================
  // Extension register
  // ==========================================
  reg [7:0] ext_r;
  reg [7:0] ext_nxt;
  always @* begin
    ext_nxt = ext_r;
    if (word_read) begin
      ext_nxt = program_memory_data_bus_in[`PMX_EXT_MSB:0];
    end else if (ext_load_dmd) begin
      ext_nxt = data_memory_data_bus_in[`PMX_EXT_MSB:0];
    end
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      ext_r <= `PMX_EXT_RST;
      pm_low_byte_extension <= `PMX_EXT_RST;
    end else begin
      ext_r <= ext_nxt;
      pm_low_byte_extension <= ext_nxt;
    end
  end

  // ==========================================
  // Wide word lanes for program memory writes
  // ==========================================
  wire [PMD_W-1:0] pm_write_word;
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
      if (lane == 0) begin : g_ext
        assign pm_write_word[lane*EXT_W +: EXT_W] = ext_r;
      end else begin : g_up
        assign pm_write_word[lane*EXT_W +: EXT_W] = data_memory_data_bus_in[(lane-1)*EXT_W +: EXT_W];
      end
    end
  endgenerate

  // ==========================================
  // Narrow word for reads
  // ==========================================
  reg [15:0] rd_word;
  always @* begin
    rd_word = program_memory_data_bus_in[`PMX_UP_MSB:`PMX_UP_LSB];
    if (ext_read_dmd) begin
      rd_word = {`PMX_ZERO_BYTE, ext_r};
    end
  end

  // ==========================================
  // Read result FIFO
  // ==========================================
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [15:0] fifo_out_data;
  pmx_fifo #(
    .WIDTH(DMD_W),
    .DEPTH(DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(read_push),
    .in_ready(fifo_in_ready),
    .in_data(rd_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ==========================================
  // Read result output stage
  // ==========================================
  // Next word moves up only when the stage is empty or taken
  assign fifo_out_ready = !rd_valid || rd_ready;
  always @(posedge core_clk) begin
    if (!resetn) begin
      rd_valid <= 1'b0;
      rd_data <= {`PMX_DMD_W{1'b0}};
    end else begin
      if (fifo_out_valid && fifo_out_ready) begin
        rd_valid <= 1'b1;
        rd_data <= fifo_out_data;
      end else if (rd_ready) begin
        rd_valid <= 1'b0;
      end
    end
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      wr_ready <= 1'b0;
    end else begin
      wr_ready <= fifo_in_ready;
    end
  end

  // ==========================================
  // Program memory data bus driver
  // ==========================================
  always @(posedge core_clk) begin
    if (!resetn) begin
      program_memory_data_bus_out <= {`PMX_PMD_W{1'b0}};
      program_memory_data_bus_oe <= 1'b0;
    end else begin
      program_memory_data_bus_oe <= write_drive;
      program_memory_data_bus_out <= pm_write_word;
    end
  end

  // ==========================================
  // Data memory data bus driver
  // ==========================================
  always @(posedge core_clk) begin
    if (!resetn) begin
      data_memory_data_bus_out <= {`PMX_DMD_W{1'b0}};
      data_memory_data_bus_oe <= 1'b0;
    end else begin
      data_memory_data_bus_oe <= read_push;
      data_memory_data_bus_out <= rd_word;
    end
  end

  // ==========================================
  // Dedicated Y operand path
  // ==========================================
  always @(posedge core_clk) begin
    if (!resetn) begin
      y_operand_data <= {`PMX_DMD_W{1'b0}};
      y_operand_valid <= 1'b0;
    end else begin
      y_operand_valid <= pm_dual_read;
      y_operand_data <= program_memory_data_bus_in[`PMX_UP_MSB:`PMX_UP_LSB];
    end
  end
endmodule

// *** shared/pmx_defs.vh ***
// Overview of operation
// - Couples 24-bit program memory data bus with 16-bit data memory bus, upper 16 direct.
// - Two one-way driver paths between narrow bus and wide bus upper 16 bits.
// - Extension register is 8 bits, loadable from low byte of either bus.
// - Extension register drivable onto low 8 bits of either bus.
// - Program memory data read: destination gets upper 16, extension captures lower 8.
// - Program memory data write places extension register on low 8 bits of word.
// - Source register supplies upper 16 bits of stored program memory word.
// - Explicit load from narrow bus keeps low 8 bits, discards upper 8.
// - Explicit read onto narrow bus gives extension byte low, upper 8 zero.
// - Dual reads route wide bus upper 16 to Y operand path, bypassing exchange.
`ifndef PMX_DEFS_VH
`define PMX_DEFS_VH
`define PMX_PMD_W 24
`define PMX_DMD_W 16
`define PMX_EXT_W 8
`define PMX_UP_LSB 8
`define PMX_UP_MSB 23
`define PMX_EXT_MSB 7
`define PMX_EXT_RST 8'h00
`define PMX_ZERO_BYTE 8'h00
`define PMX_FIFO_DEPTH 4
`endif

// *** src/pmx_fifo.v ***
`timescale 1ns/1ps
module pmx_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wptr_r;
  reg [AW-1:0] rptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;
  wire empty_mem;
  assign empty_mem = (count_r == {(AW+1){1'b0}});
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  assign pop = !empty_mem && (!out_valid || out_ready);
  always @(posedge core_clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end
  always @(posedge core_clk) begin
    if (!resetn) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
        out_data <= mem_r[rptr_r];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// *** tb/pmx_sva.sv ***
`timescale 1ns/1ps
module pmx_sva (
  input wire core_clk, resetn, pm_data_read, pm_data_write, pm_dual_read, ext_load_dmd, ext_read_dmd,
  input wire wr_valid, program_memory_data_bus_oe, data_memory_data_bus_oe, y_operand_valid,
  input wire [23:0] program_memory_data_bus_in, program_memory_data_bus_out,
  input wire [15:0] data_memory_data_bus_in, data_memory_data_bus_out, y_operand_data,
  input wire [7:0] pm_low_byte_extension
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_read_word:
    assert property (pm_data_read && !pm_dual_read |=> data_memory_data_bus_oe &&
      data_memory_data_bus_out == $past(program_memory_data_bus_in[23:8])) else $error("read word");
  a_read_ext:
    assert property (pm_data_read && !pm_dual_read |=>
      pm_low_byte_extension == $past(program_memory_data_bus_in[7:0])) else $error("read ext");
  a_write_word:
    assert property (pm_data_write && wr_valid |=> program_memory_data_bus_oe &&
      program_memory_data_bus_out[23:8] == $past(data_memory_data_bus_in)) else $error("write word");
  a_write_ext:
    assert property (pm_data_write && wr_valid |=>
      program_memory_data_bus_out[7:0] == $past(pm_low_byte_extension)) else $error("write ext");
  a_load_low:
    assert property (ext_load_dmd && !pm_data_read |=>
      pm_low_byte_extension == $past(data_memory_data_bus_in[7:0])) else $error("load ext");
  a_ext_out:
    assert property (ext_read_dmd |=> data_memory_data_bus_oe &&
      data_memory_data_bus_out == {8'h00, $past(pm_low_byte_extension)}) else $error("ext out");
  a_y_path:
    assert property (pm_dual_read |=> y_operand_valid &&
      y_operand_data == $past(program_memory_data_bus_in[23:8])) else $error("y path");
  a_ext_hold:
    assert property (!(pm_data_read && !pm_dual_read) && !ext_load_dmd |=>
      $stable(pm_low_byte_extension)) else $error("ext hold");
endmodule
bind pmx_exchange pmx_sva u_sva (.core_clk, .resetn, .pm_data_read, .pm_data_write, .pm_dual_read,
  .ext_load_dmd, .ext_read_dmd, .wr_valid, .program_memory_data_bus_oe, .data_memory_data_bus_oe,
  .y_operand_valid, .program_memory_data_bus_in, .program_memory_data_bus_out,
  .data_memory_data_bus_in, .data_memory_data_bus_out, .y_operand_data, .pm_low_byte_extension);

// *** tb/pmx_pm_model.sv ***
`timescale 1ns/1ps
module pmx_pm_model (
  input wire core_clk, rd_en, wr_oe,
  input wire [23:0] wr_word,
  output logic [23:0] rd_word
);
  logic [23:0] mem = 24'habcdef;
  always @(posedge core_clk) if (wr_oe) mem <= wr_word;
  // Released bus shows inverse
  assign rd_word = rd_en ? mem : ~mem;
endmodule

// *** tb/pmx_exchange_bench.sv ***
`timescale 1ns/1ps
module pmx_exchange_bench;
  logic core_clk = 0, resetn = 0, rd = 0, wr = 0, du = 0, ld = 0, rx = 0;
  logic [15:0] dmd_in = 16'h0000;
  wire [23:0] pmd_in, pmd_out;
  wire [15:0] dmd_out, y;
  wire [7:0] ext;
  wire pmd_oe, dmd_oe;
  wire rdv, wrr, yv;
  wire [15:0] rdd;
  int n_fail = 0, checks_done = 0;
  initial forever #12.5 core_clk = ~core_clk;
  pmx_exchange u_dut (.core_clk(core_clk), .resetn(resetn), .program_memory_data_bus_in(pmd_in),
    .program_memory_data_bus_out(pmd_out), .program_memory_data_bus_oe(pmd_oe),
    .data_memory_data_bus_in(dmd_in), .data_memory_data_bus_out(dmd_out), .data_memory_data_bus_oe(dmd_oe),
    .pm_data_read(rd), .pm_data_write(wr), .pm_dual_read(du), .ext_load_dmd(ld), .ext_read_dmd(rx),
    .wr_valid(wr), .wr_ready(wrr), .rd_valid(rdv), .rd_ready(1'b1), .rd_data(rdd), .y_operand_data(y),
    .y_operand_valid(yv), .pm_low_byte_extension(ext));
  pmx_pm_model u_pm (.core_clk(core_clk), .rd_en(rd | du), .wr_oe(pmd_oe), .wr_word(pmd_out), .rd_word(pmd_in));
  task chk(string nm, logic [23:0] e, logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_rd(logic [15:0] e);
    int i;
    i = 0;
    while (i < 8 && rdv !== 1'b1) begin
      @(posedge core_clk); #2;
      i++;
    end
    if (rdv !== 1'b1) begin
      n_fail++;
      $display("wrong value rd_valid exp 1 got 0");
      wrap_up;
    end else begin
      chk("rd_data", e, rdd);
    end
  endtask
  task op(logic [4:0] c, logic [15:0] d);
    @(posedge core_clk); #2;
    {rd, wr, du, ld, rx} = c;
    dmd_in = d;
    @(posedge core_clk); #2;
    {rd, wr, du, ld, rx} = 5'h00;
  endtask
  task wrap_up;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    #2 resetn = 1;
    op(5'h10, 16'h0000); chk("dmd", 24'h00abcd, dmd_out);
    chk("dmd_oe", 24'h1, dmd_oe);
    chk("ext", 24'hef, ext);
    chk_rd(16'habcd);
    op(5'h00, 16'h0000); chk("ext", 24'hef, ext);
    $display("test read done");
    op(5'h02, 16'h1234); chk("ext", 24'h34, ext);
    op(5'h01, 16'h0000); chk("dmd", 24'h0034, dmd_out);
    chk_rd(16'h0034);
    $display("test ext done");
    op(5'h08, 16'h5678); chk("pmd", 24'h567834, pmd_out);
    chk("pmd_oe", 24'h1, pmd_oe);
    chk("wr_ready", 24'h1, wrr);
    op(5'h10, 16'h0000); chk("dmd", 24'h5678, dmd_out);
    chk_rd(16'h5678);
    $display("test write done");
    op(5'h02, 16'h0099); op(5'h04, 16'h0000); chk("y", 24'h5678, y);
    chk("ext", 24'h99, ext);
    chk("y_oe", 24'h1, yv);
    $display("test dual done");
    wrap_up;
  end
endmodule
